// ===== core/rtcic_pkg.sv
// Package of constants for the real time clock interrupt control block.
// Notes on behaviour
// - Watchdog timeout with its enable set drives the interrupt pin and sets its flag.
// - Watchdog timeout with its enable clear sets only the watchdog flag.
// - Alarm match with its enable set drives the interrupt pin and sets its flag.
// - Alarm match with its enable clear sets only the alarm flag.
// - Power failure with its enable set drives the interrupt pin and sets its flag.
// - Power failure with its enable clear sets only the power fail flag.
// - Polarity bit one drives the interrupt pin actively high.
// - Polarity bit zero makes the pin open drain, pulled low when active.
// - Pulse mode holds the pin active about 200 ms per enabled event.
// - Level mode holds the pin active until the host reads the flags register.
// - Control bits D4, D1 and D0 are reserved and read as zero.
package rtcic_pkg;

    localparam int ADDR_W = 22;
    localparam int DATA_W = 32;
    localparam int INDEX_W = 20;

    // Register indices; the byte address is four times the index.
    localparam logic [INDEX_W-1:0] CTRL_INDEX  = 20'hffff6;
    localparam logic [INDEX_W-1:0] FLAGS_INDEX = 20'hffff0;
    localparam logic [INDEX_W-1:0] CLEAR_INDEX = 20'hffff1;
    localparam logic [INDEX_W-1:0] IRQEN_INDEX = 20'hffff2;

    // Interrupt control register fields.
    localparam int CTRL_WDT_EN_BIT = 7;
    localparam int CTRL_ALM_EN_BIT = 6;
    localparam int CTRL_PF_EN_BIT  = 5;
    localparam int CTRL_HIGH_BIT   = 3;
    localparam int CTRL_PULSE_BIT  = 2;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] CTRL_RSV_MASK = 8'h13;
    localparam logic [7:0] CTRL_RW_MASK  = 8'hec;

    // Flag, clear and enable registers share this layout.
    localparam int FLAG_W       = 3;
    localparam int FLAG_WDT_BIT = 0;
    localparam int FLAG_ALM_BIT = 1;
    localparam int FLAG_PF_BIT  = 2;
    localparam logic [FLAG_W-1:0] FLAG_RESET = 3'h0;

    // Pulse timing: 200 ms built from 1 ms ticks of the 5 ns clock.
    localparam int CLOCK_PERIOD_NS = 5;
    localparam int TICK_PERIOD_NS  = 1000000;
    localparam int PULSE_MS        = 200;
    localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLOCK_PERIOD_NS;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [INDEX_W-1:0] index);
        byte_addr = {index, 2'b00};
    endfunction

endpackage

// ===== core/rtcic_pulse_timer.sv
// Retriggerable pulse stretcher built from a tick divider and a tick counter.
`timescale 1ns/1ps
`default_nettype none
module rtcic_pulse_timer
    import rtcic_pkg::*;
#(
    parameter int TICK_LEN   = TICK_CYCLES,
    parameter int PULSE_LEN  = PULSE_MS
) (
    // Clock and reset.
    input  wire logic clock,
    input  wire logic rstn,
    // Control.
    input  wire logic start,
    output logic      busy
);

    localparam int DIV_W = $clog2(TICK_LEN + 1);
    localparam int CNT_W = $clog2(PULSE_LEN + 1);

    logic [DIV_W-1:0] div_reg;
    logic [CNT_W-1:0] count_reg;
    logic             tick;

    assign tick = (div_reg == DIV_W'(TICK_LEN - 1));
    assign busy = (count_reg != '0);

    // The divider restarts on each trigger so every pulse is full length.
    always_ff @(posedge clock) begin
        if (!rstn || start || !busy || tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + DIV_W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            count_reg <= '0;
        end else if (start) begin
            count_reg <= CNT_W'(PULSE_LEN);
        end else if (busy && tick) begin
            count_reg <= count_reg - CNT_W'(1);
        end
    end

    a_pulse_ends: assert property (@(posedge clock) disable iff (!rstn)
        (count_reg == CNT_W'(1) && tick && !start) |=> !busy)
        else $error("pulse did not end after its last tick");

    a_pulse_starts: assert property (@(posedge clock) disable iff (!rstn)
        start |=> (count_reg == CNT_W'(PULSE_LEN)))
        else $error("pulse did not load its full length");

endmodule
`default_nettype wire

// ===== core/rtcic_top.sv
// Interrupt enable, flag and output shaping logic with an Avalon-MM register slave.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module rtcic_top
    import rtcic_pkg::*;
#(
    parameter int TICK_LEN  = TICK_CYCLES,
    parameter int PULSE_LEN = PULSE_MS
) (
    // Clock and reset.
    input  wire logic              clock,
    input  wire logic              rstn,
    // Avalon-MM slave.
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    // Event sources.
    input  wire logic              watchdog_timeout,
    input  wire logic              alarm_match,
    input  wire logic              power_fail,
    // Interrupt pin.
    output logic                   int_out,
    output logic                   int_oe,
    // System interrupt.
    output logic                   irq
);

    logic [7:0]        ctrl_reg;
    logic [FLAG_W-1:0] flags_reg;
    logic [FLAG_W-1:0] flags_next;
    logic [FLAG_W-1:0] irq_en_reg;
    logic              ack_reg;
    logic [DATA_W-1:0] readdata_reg;
    logic              rd_ctrl_reg;
    logic              level_reg;
    logic              int_active;
    logic              irq_request;
    logic [FLAG_W-1:0] events;
    logic              access;
    logic              wr_done;
    logic              rd_done;
    logic              wr_lane;
    logic              sel_ctrl;
    logic              sel_flags;
    logic              sel_clear;
    logic              sel_irqen;
    logic              flags_read;
    logic              pulse_busy;
    logic              wdt_en;
    logic              alm_en;
    logic              pf_en;
    logic              drive_high;
    logic              pulse_mode;

    assign wdt_en     = ctrl_reg[CTRL_WDT_EN_BIT];
    assign alm_en     = ctrl_reg[CTRL_ALM_EN_BIT];
    assign pf_en      = ctrl_reg[CTRL_PF_EN_BIT];
    assign drive_high = ctrl_reg[CTRL_HIGH_BIT];
    assign pulse_mode = ctrl_reg[CTRL_PULSE_BIT];

    // Bus decode: one wait cycle, then the access completes.
    assign access    = avs_read || avs_write;
    assign avs_waitrequest = access && !ack_reg;
    assign wr_done   = avs_write && ack_reg;
    assign rd_done   = avs_read && ack_reg;
    assign wr_lane   = wr_done && avs_byteenable[0];
    assign sel_ctrl  = (avs_address == byte_addr(CTRL_INDEX));
    assign sel_flags = (avs_address == byte_addr(FLAGS_INDEX));
    assign sel_clear = (avs_address == byte_addr(CLEAR_INDEX));
    assign sel_irqen = (avs_address == byte_addr(IRQEN_INDEX));
    assign flags_read = rd_done && sel_flags;
    assign avs_readdata = readdata_reg;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access && !ack_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            readdata_reg <= '0;
            rd_ctrl_reg  <= 1'b0;
        end else if (avs_read && !ack_reg) begin
            rd_ctrl_reg <= sel_ctrl;
            if (sel_ctrl) begin
                readdata_reg <= DATA_W'(ctrl_reg & CTRL_RW_MASK);
            end else if (sel_flags) begin
                readdata_reg <= DATA_W'(flags_reg);
            end else if (sel_irqen) begin
                readdata_reg <= DATA_W'(irq_en_reg);
            end else begin
                readdata_reg <= '0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_lane && sel_ctrl) begin
            ctrl_reg <= avs_writedata[7:0] & CTRL_RW_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            irq_en_reg <= FLAG_RESET;
        end else if (wr_lane && sel_irqen) begin
            irq_en_reg <= avs_writedata[FLAG_W-1:0];
        end
    end

    // Each source sets its flag whatever its enable says.
    assign events[FLAG_WDT_BIT] = watchdog_timeout;
    assign events[FLAG_ALM_BIT] = alarm_match;
    assign events[FLAG_PF_BIT]  = power_fail;

    // flags always set, event beats clear.
    always_comb begin
        flags_next = flags_reg;
        if (wr_lane && sel_clear) begin
            flags_next = flags_next & ~avs_writedata[FLAG_W-1:0];
        end
        flags_next = flags_next | events;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            flags_reg <= FLAG_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign irq = |(flags_reg & irq_en_reg);

    assign irq_request = (watchdog_timeout && wdt_en)
                       || (alarm_match && alm_en)
                       || (power_fail && pf_en);

    // level held until the flags register is read.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            level_reg <= 1'b0;
        end else if (irq_request) begin
            level_reg <= 1'b1;
        end else if (flags_read) begin
            level_reg <= 1'b0;
        end
    end

    rtcic_pulse_timer #(
        .TICK_LEN  (TICK_LEN),
        .PULSE_LEN (PULSE_LEN)
    ) u_pulse (
        .clock (clock),
        .rstn  (rstn),
        .start (irq_request && pulse_mode),
        .busy  (pulse_busy)
    );

    assign int_active = pulse_mode ? pulse_busy : level_reg;

    assign int_out = drive_high ? int_active : 1'b0;
    assign int_oe  = drive_high ? 1'b1 : int_active;

    a_wdt_flag_set: assert property (@(posedge clock) disable iff (!rstn)
        watchdog_timeout |=> flags_reg[FLAG_WDT_BIT])
        else $error("watchdog flag not set by timeout");

    a_alarm_flag_set: assert property (@(posedge clock) disable iff (!rstn)
        alarm_match |=> flags_reg[FLAG_ALM_BIT])
        else $error("alarm flag not set by match");

    a_pf_flag_set: assert property (@(posedge clock) disable iff (!rstn)
        power_fail |=> flags_reg[FLAG_PF_BIT])
        else $error("power fail flag not set");

    a_wdt_drives_int: assert property (@(posedge clock) disable iff (!rstn)
        (watchdog_timeout && wdt_en && !(wr_lane && sel_ctrl)) |=> int_active)
        else $error("enabled watchdog timeout did not assert interrupt");

    a_alarm_drives_int: assert property (@(posedge clock) disable iff (!rstn)
        (alarm_match && alm_en && !(wr_lane && sel_ctrl)) |=> int_active)
        else $error("enabled alarm match did not assert interrupt");

    a_pf_drives_int: assert property (@(posedge clock) disable iff (!rstn)
        (power_fail && pf_en && !(wr_lane && sel_ctrl)) |=> int_active)
        else $error("enabled power fail did not assert interrupt");

    a_masked_stays_quiet: assert property (@(posedge clock) disable iff (!rstn)
        (!irq_request && !int_active && !level_reg && !pulse_busy)
            |=> !int_active)
        else $error("interrupt asserted with no enabled source");

    a_high_polarity: assert property (@(posedge clock) disable iff (!rstn)
        drive_high |-> (int_oe && (int_out == int_active)))
        else $error("active high output not driven correctly");

    a_open_drain: assert property (@(posedge clock) disable iff (!rstn)
        !drive_high |-> (!int_out && (int_oe == int_active)))
        else $error("open drain output not driven correctly");

    a_level_hold: assert property (@(posedge clock) disable iff (!rstn)
        (!pulse_mode && level_reg && !flags_read && !(wr_lane && sel_ctrl))
            |=> int_active)
        else $error("level interrupt released without flags read");

    a_level_release: assert property (@(posedge clock) disable iff (!rstn)
        (!pulse_mode && flags_read && !irq_request && !(wr_lane && sel_ctrl))
            |=> !int_active)
        else $error("level interrupt not released by flags read");

    a_reserved_zero: assert property (@(posedge clock) disable iff (!rstn)
        (rd_ctrl_reg && !avs_waitrequest && avs_read)
            |-> ((avs_readdata[7:0] & CTRL_RSV_MASK) == 8'h00))
        else $error("reserved control bits read nonzero");

    a_wait_one_cycle: assert property (@(posedge clock) disable iff (!rstn)
        (access && !ack_reg) |=> (!access || !avs_waitrequest))
        else $error("bus access not completed after one wait cycle");

endmodule
`default_nettype wire

// ===== verification/rtcic_host_model.sv
// Host processor model: Avalon-MM master and the pulled-up interrupt line.
`timescale 1ns/1ps
`default_nettype none
module rtcic_host_model
    import rtcic_pkg::*;
(
    // Clock.
    input  wire logic              clock,
    // Bus master side.
    output logic      [ADDR_W-1:0] avs_address,
    output logic                   avs_read,
    output logic                   avs_write,
    output logic      [DATA_W-1:0] avs_writedata,
    output logic      [3:0]        avs_byteenable,
    input  wire logic [DATA_W-1:0] avs_readdata,
    input  wire logic              avs_waitrequest,
    // Interrupt line.
    input  wire logic              int_out,
    input  wire logic              int_oe,
    output wire logic              int_pin
);
    initial begin
        avs_address    = '0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = '0;
        avs_byteenable = 4'h0;
    end

    assign int_pin = int_oe ? int_out : 1'b1;

    // One transfer; the request is held until waitrequest is sampled low.
    task automatic xfer(input logic is_wr, input logic [ADDR_W-1:0] a,
                        input logic [7:0] d, output logic [DATA_W-1:0] q);
        int n;
        @(posedge clock);
        avs_address    <= a;
        avs_read       <= !is_wr;
        avs_write      <= is_wr;
        avs_writedata  <= {24'h000000, d};
        avs_byteenable <= 4'h1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest && n < 50);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest) begin
            $display("ERROR %0t waitrequest %h exp %h", $time, avs_waitrequest, 1'b0);
            tb.fails++;
            tb.test_done();
        end
    endtask

    task automatic ack_flags(output logic [DATA_W-1:0] q);
        xfer(1'b0, byte_addr(FLAGS_INDEX), 8'h00, q);
    endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Self-checking testbench for the interrupt control block.
`timescale 1ns/1ps
`default_nettype none
module tb
    import rtcic_pkg::*;
;
    localparam int TB_TICK   = 4;
    localparam int TB_PULSE  = 3;
    localparam int PULSE_CYC = TB_TICK * TB_PULSE;
    logic              clock = 1'b0;
    logic              rstn  = 1'b0;
    logic [2:0]        evt   = 3'h0;
    wire  [ADDR_W-1:0] address;
    wire               read;
    wire               write;
    wire  [DATA_W-1:0] wdata;
    wire  [3:0]        be;
    wire  [DATA_W-1:0] rdata;
    wire               waitreq;
    wire               int_out;
    wire               int_oe;
    wire               int_pin;
    wire               irq;
    logic [DATA_W-1:0] q;
    int                fails = 0;
    int                num_checks = 0;

    always #2.5 clock = ~clock;

    rtcic_top #(.TICK_LEN(TB_TICK), .PULSE_LEN(TB_PULSE)) rtcic_top_inst (
        .clock(clock), .rstn(rstn), .avs_address(address), .avs_read(read),
        .avs_write(write), .avs_writedata(wdata), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(waitreq),
        .watchdog_timeout(evt[0]), .alarm_match(evt[1]), .power_fail(evt[2]),
        .int_out(int_out), .int_oe(int_oe), .irq(irq));

    rtcic_host_model rtcic_host_model_inst (
        .clock(clock), .avs_address(address), .avs_read(read), .avs_write(write),
        .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(waitreq), .int_out(int_out), .int_oe(int_oe),
        .int_pin(int_pin));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [INDEX_W-1:0] idx, input logic [7:0] d);
        rtcic_host_model_inst.xfer(1'b1, byte_addr(idx), d, q);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        rtcic_host_model_inst.xfer(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask

    // Pulses one event source for a cycle and lets the result settle.
    task automatic ev(input int i);
        @(posedge clock);
        evt <= 3'h1 << i;
        @(posedge clock);
        evt <= 3'h0;
        @(negedge clock);
    endtask

    task automatic t_reset();
        rd(byte_addr(CTRL_INDEX), 32'h0);
        rd(byte_addr(FLAGS_INDEX), 32'h0);
        rd(22'h000100, 32'h0);
        @(negedge clock);
        chk({int_oe, irq}, 2'b00);
        wr(CTRL_INDEX, 8'hff);
        rd(byte_addr(CTRL_INDEX), 32'hec);
    endtask

    task automatic t_disabled();
        wr(CTRL_INDEX, 8'h08);
        for (int i = 0; i < 3; i++) begin
            ev(i);
            chk({int_oe, int_out}, 2'b10);
        end
        rd(byte_addr(FLAGS_INDEX), 32'h7);
        wr(CLEAR_INDEX, 8'h07);
    endtask

    task automatic t_enabled();
        for (int i = 0; i < 3; i++) begin
            wr(CTRL_INDEX, (8'h80 >> i) | 8'h08);
            ev(i);
            chk({int_oe, int_out}, 2'b11);
            rtcic_host_model_inst.ack_flags(q);
            chk(q, 32'h1 << i);
            @(negedge clock);
            chk(int_out, 1'b0);
            wr(CLEAR_INDEX, 8'h07);
        end
    endtask

    task automatic t_open_drain();
        wr(CTRL_INDEX, 8'he0);
        ev(1);
        chk({int_oe, int_out, int_pin}, 3'b100);
        rtcic_host_model_inst.ack_flags(q);
        @(negedge clock);
        chk({int_oe, int_pin}, 2'b01);
        wr(CLEAR_INDEX, 8'h07);
    endtask

    task automatic t_pulse();
        wr(CTRL_INDEX, 8'h8c);
        ev(0);
        repeat (PULSE_CYC - 1) @(negedge clock);
        chk(int_out, 1'b1);
        repeat (1) @(negedge clock);
        chk(int_out, 1'b0);
        rd(byte_addr(FLAGS_INDEX), 32'h1);
        wr(CLEAR_INDEX, 8'h07);
    endtask

    task automatic t_irq();
        // Watchdog source masked so the pin stays idle while irq is exercised.
        wr(CTRL_INDEX, 8'h08);
        wr(IRQEN_INDEX, 8'h01);
        ev(0);
        chk(irq, 1'b1);
        wr(IRQEN_INDEX, 8'h00);
        @(negedge clock);
        chk(irq, 1'b0);
        wr(IRQEN_INDEX, 8'h01);
        wr(CLEAR_INDEX, 8'h01);
        @(negedge clock);
        chk({irq, int_out}, 2'b00);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        t_reset();
        t_disabled();
        t_enabled();
        t_open_drain();
        t_pulse();
        t_irq();
        test_done();
    end
endmodule
`default_nettype wire
